/* hdl/spc_pkg.sv */
package spc_pkg;
  // register placement
  localparam logic [7:0] SPC_CSR_DATA_ADDR = 8'h57;
  localparam logic [7:0] SPC_IO_OFFSET = 8'h20;
  localparam logic [7:0] SPC_CSR_RESET = 8'h00;
  // field positions
  localparam int SPC_BIT_EN = 0;
  localparam int SPC_BIT_ERS = 1;
  localparam int SPC_BIT_WRT = 2;
  localparam int SPC_BIT_LFS = 3;
  localparam int SPC_BIT_RRE = 4;
  localparam int SPC_BIT_SIG = 5;
  localparam int SPC_BIT_BSY = 6;
  localparam int SPC_BIT_IE = 7;
  // command codes in the low five bits, signature read in the low six
  localparam logic [4:0] SPC_CMD_FILL = 5'h01;
  localparam logic [4:0] SPC_CMD_ERASE = 5'h03;
  localparam logic [4:0] SPC_CMD_WRITE = 5'h05;
  localparam logic [4:0] SPC_CMD_LOCK = 5'h09;
  localparam logic [4:0] SPC_CMD_RWWRE = 5'h11;
  localparam logic [5:0] SPC_CMD_SIG = 6'h21;
  // arming windows in cycles
  localparam int SPC_STORE_WINDOW = 4;
  localparam int SPC_LOAD_WINDOW = 3;
  // fuse byte pointers
  localparam logic [15:0] SPC_FUSE_LOW_PTR = 16'h0000;
  localparam logic [15:0] SPC_FUSE_EXT_PTR = 16'h0002;
  localparam logic [15:0] SPC_FUSE_HIGH_PTR = 16'h0003;
  // programming time
  localparam int SPC_CLK_MHZ = 250;
  localparam int SPC_PROG_MIN_NS = 3200000;
  localparam int SPC_PROG_MAX_NS = 3400000;
  localparam int SPC_PROG_CYCLES = (SPC_PROG_MIN_NS * SPC_CLK_MHZ + 999) / 1000;
endpackage

/* hdl/spc_timer.sv */
`timescale 1ns/10ps
module spc_timer #(
  parameter int WIDTH = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic busy;
    logic done;
  } spc_tmr_t;
  spc_tmr_t s, next_s;

  initial begin
    if (WIDTH < 2) $error("timer width too small");
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cnt = length;
    end else if (s.busy) begin
      if (s.cnt <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
endmodule

/* hdl/spc_ctrl.sv */
`timescale 1ns/10ps
// Functional notes
// R1 - register at data offset 0x57 and at I/O offset 0x37.
// R2 - ready interrupt requested while enabled, global flag set, enable clear.
// R3 - no ready interrupt during EEPROM write or store-program.
// R4 - without read-while-write the busy bit always reads zero.
// R5 - signature read: load within three cycles returns signature byte.
// R6 - store-program within four cycles of signature read does nothing.
// R7 - writing section read-enable during buffer fill clears page buffer.
// R8 - lock-set read returns lock or fuse bits chosen by pointer bit 0; the code picks by the whole pointer value.
// R9 - page-write command writes buffer to page from upper pointer bits.
// R10 - page-write bit clears at finish or after four idle cycles.
// R11 - page-erase command erases page from upper pointer bits.
// R12 - page-erase bit clears at finish or after four idle cycles.
// R13 - enable alone stores data pair into buffer word, pointer bit 0 ignored.
// R14 - enable arms store for four cycles, clears on completion or timeout.
// R15 - enable stays set through a whole erase or write.
// R16 - low five bits ignored unless enable alone or with one command.
// R17 - store-program starts only from the boot loader section.
// R18 - boot loader store-program may erase or write any page.
// R19 - boot-size fuses set section sizes; here the section start comes from the NO_READ_WHILE_WRITE_SECTION_START input.
// R20 - programming in read-while-write section lets fetches continue.
// R21 - programming in no-read-while-write section halts the CPU.
// R22 - busy bit reads one while read-while-write section is blocked.
// R23 - programmed fuse and lock bits read zero, unprogrammed read one.
// R24 - fuse pointer 0x0000 low, 0x0003 high, 0x0002 extended byte.
// R25 - each erase, write or lock write takes 3.2 to 3.4 ms; here a lock write store starts no timed operation.
// R26 - section read-enable plus store clears busy after programming.
module spc_ctrl
  import spc_pkg::*;
#(
  parameter bit HAS_RWW = 1'b1,
  parameter int PAGE_WORDS = 64,
  parameter int PROG_CYCLES = spc_pkg::SPC_PROG_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // cpu register access
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_SPACE,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  // cpu instruction side
  input wire logic STORE_EXEC,
  input wire logic LOAD_EXEC,
  input wire logic [15:0] Z_PTR,
  input wire logic [15:0] R1R0,
  input wire logic FROM_BOOT,
  input wire logic GLOBAL_IE,
  input wire logic EE_WRITE_BUSY,
  output logic LOAD_HIT,
  output logic [7:0] LOAD_DATA,
  output logic CPU_HALT,
  output logic READY_IRQ,
  // section map and nonvolatile bits
  input wire logic [15:0] NO_READ_WHILE_WRITE_SECTION_START,
  input wire logic [7:0] LOCK_BITS,
  input wire logic [7:0] FUSE_LOW,
  input wire logic [7:0] FUSE_HIGH,
  input wire logic [7:0] FUSE_EXT,
  input wire logic [7:0] SIG_BYTE,
  // flash array
  output logic FL_ERASE,
  output logic FL_WRITE,
  output logic [15:0] FL_PAGE_ADDR,
  output logic [15:0] FL_BUF_WORD,
  output logic [15:0] FL_BUF_ADDR
);
  import spc_pkg::*;

  localparam int AW = $clog2(PAGE_WORDS);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  initial begin
    if (PAGE_WORDS < 2 || PAGE_WORDS > 256) $error("bad page size");
    if (PROG_CYCLES < 1) $error("bad programming time");
    if ((PAGE_WORDS & (PAGE_WORDS - 1)) != 0) $error("page not power of two");
  end

  typedef enum logic [1:0] {SPC_IDLE, SPC_ARMED, SPC_PROG} spc_st_t;

  typedef struct packed {
    spc_st_t st;
    logic [7:0] csr;
    logic [2:0] win;
    logic rww_busy;
    logic no_read_while_write_section_op;
    logic sig_lock;
    logic [15:0] page;
    logic [PAGE_WORDS-1:0] buf_valid;
    logic [7:0] rdata;
    logic load_hit;
    logic [7:0] load_data;
    logic halt;
    logic irq;
    logic fl_erase;
    logic fl_write;
    logic [15:0] fl_word;
    logic [15:0] fl_addr;
  } spc_state_t;

  spc_state_t s, next_s;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic [15:0] page_buf [PAGE_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic cmd_ok(input logic [4:0] c);
    cmd_ok = (c == SPC_CMD_FILL) || (c == SPC_CMD_ERASE) ||
             (c == SPC_CMD_WRITE) || (c == SPC_CMD_LOCK) ||
             (c == SPC_CMD_RWWRE);
  endfunction

  function automatic logic [7:0] fuse_pick(input logic [15:0] z,
      input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ex,
      input logic [7:0] lk);
    if (z == SPC_FUSE_LOW_PTR) fuse_pick = lo;
    else if (z == SPC_FUSE_HIGH_PTR) fuse_pick = hi;
    else if (z == SPC_FUSE_EXT_PTR) fuse_pick = ex;
    else fuse_pick = lk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic csr_sel;
  logic csr_wr;
  logic [4:0] low5;
  logic store_ok;
  logic [AW-1:0] widx;
  // both access paths
  // R1 dual address decode
  assign csr_sel = IO_SPACE ? (IO_ADDR == SPC_CSR_DATA_ADDR - SPC_IO_OFFSET)
                            : (IO_ADDR == SPC_CSR_DATA_ADDR);
  assign csr_wr = IO_WR && csr_sel;
  assign low5 = s.csr[4:0];
  // R17 R19 boot section only
  assign store_ok = STORE_EXEC && FROM_BOOT && s.st == SPC_ARMED &&
                    !s.sig_lock;
  assign widx = Z_PTR[AW:1];

  always_comb begin
    next_s = s;
    tmr_start = 1'b0;
    next_s.fl_erase = 1'b0;
    next_s.fl_write = 1'b0;
    next_s.load_hit = 1'b0;
    unique case (s.st)
      SPC_IDLE: begin
        if (csr_wr) begin
          next_s.csr[SPC_BIT_IE] = IO_WDATA[SPC_BIT_IE];
          // R16 legal combinations
          if (cmd_ok(IO_WDATA[4:0]) || IO_WDATA[5:0] == SPC_CMD_SIG[5:0]) begin
            next_s.csr[5:0] = IO_WDATA[5:0];
            next_s.st = SPC_ARMED;
            next_s.win = 3'(SPC_STORE_WINDOW);
            next_s.sig_lock = IO_WDATA[SPC_BIT_SIG];
            // R7 buffer cleared
            if (IO_WDATA[SPC_BIT_RRE] && |s.buf_valid) begin
              next_s.buf_valid = '0;
            end
          end
        end
      end
      SPC_ARMED: begin
        if (csr_wr) begin
          next_s.csr[SPC_BIT_IE] = IO_WDATA[SPC_BIT_IE];
        end
        // R5 R8 load window
        if (LOAD_EXEC && s.win > 3'(SPC_STORE_WINDOW - SPC_LOAD_WINDOW)) begin
          if (s.csr[SPC_BIT_SIG]) begin
            next_s.load_hit = 1'b1;
            next_s.load_data = SIG_BYTE;
          end else if (s.csr[SPC_BIT_LFS]) begin
            next_s.load_hit = 1'b1;
            // R23 R24 fuse select
            next_s.load_data = Z_PTR[0] ?
              fuse_pick(Z_PTR, FUSE_LOW, FUSE_HIGH, FUSE_EXT, LOCK_BITS) :
              fuse_pick(Z_PTR, FUSE_LOW, FUSE_HIGH, FUSE_EXT, LOCK_BITS);
          end
        end
        if (store_ok) begin
          if (low5 == SPC_CMD_FILL) begin
            // R13 buffer word store
            next_s.buf_valid[widx] = 1'b1;
            next_s.csr[5:0] = '0;
            next_s.st = SPC_IDLE;
          end else if (low5 == SPC_CMD_ERASE || low5 == SPC_CMD_WRITE) begin
            // R9 R11 R18 page op
            next_s.page = Z_PTR & ~16'(2 * PAGE_WORDS - 1);
            next_s.fl_erase = low5 == SPC_CMD_ERASE;
            next_s.fl_write = low5 == SPC_CMD_WRITE;
            next_s.fl_addr = Z_PTR & ~16'(2 * PAGE_WORDS - 1);
            tmr_start = 1'b1;
            next_s.st = SPC_PROG;
            // R20 R21 R22 section
            next_s.no_read_while_write_section_op = Z_PTR >= NO_READ_WHILE_WRITE_SECTION_START;
            next_s.halt = Z_PTR >= NO_READ_WHILE_WRITE_SECTION_START;
            next_s.rww_busy = HAS_RWW && Z_PTR < NO_READ_WHILE_WRITE_SECTION_START;
          end else if (low5 == SPC_CMD_RWWRE) begin
            // R26 section unblocked
            next_s.rww_busy = 1'b0;
            next_s.buf_valid = '0;
            next_s.csr[5:0] = '0;
            next_s.st = SPC_IDLE;
          end else begin
            next_s.csr[5:0] = '0;
            next_s.st = SPC_IDLE;
          end
        end else if (s.win <= 3'd1) begin
          // R6 R10 R12 R14 timeout
          next_s.csr[5:0] = '0;
          next_s.sig_lock = 1'b0;
          next_s.st = SPC_IDLE;
        end else begin
          next_s.win = s.win - 3'd1;
        end
      end
      SPC_PROG: begin
        if (csr_wr) begin
          next_s.csr[SPC_BIT_IE] = IO_WDATA[SPC_BIT_IE];
        end
        // R15 R25 enable held until done
        if (tmr_done) begin
          next_s.csr[5:0] = '0;
          next_s.halt = 1'b0;
          if (low5 == SPC_CMD_WRITE) next_s.buf_valid = '0;
          next_s.st = SPC_IDLE;
        end
      end
    endcase
    // R2 R3 ready interrupt
    next_s.irq = next_s.csr[SPC_BIT_IE] && GLOBAL_IE &&
                 !next_s.csr[SPC_BIT_EN] && !EE_WRITE_BUSY &&
                 next_s.st == SPC_IDLE;
    // R4 R22 busy readback
    next_s.rdata = {next_s.csr[7], HAS_RWW ? next_s.rww_busy : 1'b0,
                    1'b0, next_s.csr[4:0]};
    next_s.fl_word = R1R0;
  end

  ////////////////////////////////////////////////////////////////////////////
  spc_timer #(.WIDTH(TW)) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .start(tmr_start),
    .length(TW'(PROG_CYCLES)),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s <= '0;
      s.csr <= SPC_CSR_RESET;
      s.st <= SPC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (store_ok && low5 == SPC_CMD_FILL) begin
      page_buf[widx] <= R1R0;
    end
  end

  assign IO_RDATA = s.rdata;
  assign LOAD_HIT = s.load_hit;
  assign LOAD_DATA = s.load_data;
  assign CPU_HALT = s.halt;
  assign READY_IRQ = s.irq;
  assign FL_ERASE = s.fl_erase;
  assign FL_WRITE = s.fl_write;
  assign FL_PAGE_ADDR = s.page;
  assign FL_BUF_WORD = s.fl_word;
  assign FL_BUF_ADDR = s.fl_addr;

  ////////////////////////////////////////////////////////////////////////////
  AST_ENABLE_TIMEOUT: assert property (@(posedge CLK) disable iff (!RST_N) // R14
    (s.st == SPC_ARMED && !STORE_EXEC)[*4] |=> s.st == SPC_IDLE)
    else $error("enable not cleared after four idle cycles");
  AST_HALT_NO_READ_WHILE_WRITE_SECTION: assert property (@(posedge CLK) disable iff (!RST_N) // R21
    s.halt |-> s.st == SPC_PROG && s.no_read_while_write_section_op)
    else $error("halt outside no_read_while_write_section programming");
  AST_EN_HELD: assert property (@(posedge CLK) disable iff (!RST_N) // R15
    s.st == SPC_PROG |-> s.csr[SPC_BIT_EN])
    else $error("enable dropped during programming");
  AST_IRQ_QUIET: assert property (@(posedge CLK) disable iff (!RST_N) // R3
    s.st == SPC_PROG |-> !s.irq)
    else $error("irq during programming");
  AST_APP_BLOCK: assert property (@(posedge CLK) disable iff (!RST_N) // R17
    (s.st == SPC_ARMED && STORE_EXEC && !FROM_BOOT) |=> !s.fl_erase && !s.fl_write)
    else $error("store from application started an operation");
  AST_BUSY_ZERO: assert property (@(posedge CLK) disable iff (!RST_N) // R4
    !HAS_RWW |-> !s.rdata[SPC_BIT_BSY])
    else $error("busy bit nonzero without rww");
  AST_SIG_NOP: assert property (@(posedge CLK) disable iff (!RST_N) // R6
    (s.st == SPC_ARMED && s.sig_lock) |=> !s.fl_erase && !s.fl_write)
    else $error("store acted after signature read");
  AST_BAD_CMD: assert property (@(posedge CLK) disable iff (!RST_N) // R16
    (s.st == SPC_IDLE && csr_wr && !cmd_ok(IO_WDATA[4:0]) &&
     IO_WDATA[5:0] != SPC_CMD_SIG[5:0]) |=> s.st == SPC_IDLE)
    else $error("illegal command accepted");
  // page erase or write taken by a store
  sequence seq_page_store;
    store_ok && (low5 == SPC_CMD_ERASE || low5 == SPC_CMD_WRITE);
  endsequence
  // buffer fill taken by a store
  sequence seq_fill_store;
    store_ok && low5 == SPC_CMD_FILL;
  endsequence
  // load inside the three-cycle window
  sequence seq_info_load;
    s.st == SPC_ARMED && LOAD_EXEC &&
    s.win > 3'(SPC_STORE_WINDOW - SPC_LOAD_WINDOW) &&
    (s.csr[SPC_BIT_SIG] || s.csr[SPC_BIT_LFS]);
  endsequence
  AST_PAGE_START: assert property (@(posedge CLK) disable iff (!RST_N) // R9
    seq_page_store |=> s.st == SPC_PROG && (s.fl_erase || s.fl_write))
    else $error("page operation not started");
  AST_PAGE_ADDR: assert property (@(posedge CLK) disable iff (!RST_N) // R11
    seq_page_store |=> s.page[15:AW+1] == $past(Z_PTR[15:AW+1]) &&
      s.page[AW:0] == '0)
    else $error("page address not from upper pointer bits");
  AST_NO_READ_WHILE_WRITE_SECTION_STALL: assert property (@(posedge CLK) disable iff (!RST_N) // R21
    seq_page_store ##0 (Z_PTR >= NO_READ_WHILE_WRITE_SECTION_START) |=> s.halt)
    else $error("no halt for no_read_while_write_section programming");
  AST_RWW_FETCH: assert property (@(posedge CLK) disable iff (!RST_N) // R20
    seq_page_store ##0 (Z_PTR < NO_READ_WHILE_WRITE_SECTION_START) |=>
      !s.halt && s.rww_busy == HAS_RWW)
    else $error("halt or busy wrong for rww programming");
  AST_FILL_DONE: assert property (@(posedge CLK) disable iff (!RST_N) // R14
    seq_fill_store |=> s.st == SPC_IDLE && !s.csr[SPC_BIT_EN])
    else $error("enable not cleared after buffer store");
  AST_FILL_WORD: assert property (@(posedge CLK) disable iff (!RST_N) // R13
    seq_fill_store |=> page_buf[$past(widx)] == $past(R1R0))
    else $error("buffer word not stored");
  AST_INFO_LOAD: assert property (@(posedge CLK) disable iff (!RST_N) // R8
    seq_info_load |=> s.load_hit)
    else $error("load in window not answered");
  AST_SIG_BYTE: assert property (@(posedge CLK) disable iff (!RST_N) // R5
    seq_info_load ##0 s.csr[SPC_BIT_SIG] |=> s.load_data == $past(SIG_BYTE))
    else $error("signature byte not returned");
  AST_RRE_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N) // R7
    s.st == SPC_IDLE && csr_wr && IO_WDATA[4:0] == SPC_CMD_RWWRE |=>
      s.buf_valid == '0)
    else $error("page buffer kept after read-enable write");
  AST_RWW_UNBLOCK: assert property (@(posedge CLK) disable iff (!RST_N) // R26
    store_ok && low5 == SPC_CMD_RWWRE |=> !s.rww_busy)
    else $error("busy kept after read-enable store");
  AST_TIMER_RUN: assert property (@(posedge CLK) disable iff (!RST_N) // R25
    s.st == SPC_PROG |-> tmr_busy || tmr_done)
    else $error("programming without running timer");
  AST_IRQ_READY: assert property (@(posedge CLK) disable iff (!RST_N) // R2
    s.st == SPC_IDLE && s.csr[SPC_BIT_IE] && GLOBAL_IE && !EE_WRITE_BUSY &&
      !csr_wr |=> s.irq)
    else $error("ready interrupt missing");
endmodule

/* tb/spc_cpu_model.sv */
`timescale 1ns/10ps
module spc_cpu_model (
  // clock
  input wire logic clk,
  // register writes
  output logic [7:0] io_addr,
  output logic io_space,
  output logic io_wr,
  output logic [7:0] io_wdata,
  // program memory instructions
  output logic store_exec,
  output logic load_exec,
  output logic [15:0] z_ptr,
  output logic [15:0] r1r0
);
  import spc_pkg::*;
  initial begin
    {io_addr, io_space, io_wr, io_wdata} = '0;
    {store_exec, load_exec, z_ptr, r1r0} = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // data or io alias
  task automatic csr_write(input logic io, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_space = io;
    io_addr = io ? SPC_CSR_DATA_ADDR - SPC_IO_OFFSET : SPC_CSR_DATA_ADDR;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d;
    io_addr = ~io_addr;
  endtask
  // store or load, strobes released low, pointer and data lines inverted
  task automatic issue(input logic st, input logic [15:0] z,
                       input logic [15:0] d);
    @(posedge clk);
    #1;
    {z_ptr, r1r0} = {z, d};
    {store_exec, load_exec} = {st, !st};
    @(posedge clk);
    #1;
    {store_exec, load_exec} = 2'b00;
    {z_ptr, r1r0} = ~{z, d};
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import spc_pkg::*;
  localparam int PROG = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic from_boot = 1'b1;
  logic global_ie = 1'b0;
  logic ee_busy = 1'b0;
  logic [7:0] lock_bits, fuse_low, fuse_high, fuse_ext, sig_byte;
  logic [15:0] data;
  logic [15:0] zs [4];
  logic [7:0] vs [4];
  wire logic [7:0] io_addr, io_wdata;
  wire logic io_space, io_wr, store_exec, load_exec;
  wire logic [15:0] z_ptr, r1r0;
  logic [7:0] io_rdata, load_data;
  logic load_hit, cpu_halt, ready_irq, fl_erase, fl_write;
  logic [15:0] fl_page_addr, fl_buf_word, fl_buf_addr;
  logic [9:0] exp_q[$];
  logic [9:0] want;
  int errors = 0;
  int comparisons = 0;
  int n;
  int seed;
  always #2 clk = ~clk;
  spc_cpu_model i_cpu (.clk(clk), .io_addr(io_addr), .io_space(io_space),
    .io_wr(io_wr), .io_wdata(io_wdata), .store_exec(store_exec),
    .load_exec(load_exec), .z_ptr(z_ptr), .r1r0(r1r0));
  spc_ctrl #(.PROG_CYCLES(PROG)) i_dut (.CLK(clk), .RST_N(rst_n),
    .IO_ADDR(io_addr), .IO_SPACE(io_space), .IO_WR(io_wr), .IO_RD(1'b0),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .STORE_EXEC(store_exec),
    .LOAD_EXEC(load_exec), .Z_PTR(z_ptr), .R1R0(r1r0),
    .FROM_BOOT(from_boot), .GLOBAL_IE(global_ie),
    .EE_WRITE_BUSY(ee_busy), .LOAD_HIT(load_hit), .LOAD_DATA(load_data),
    .CPU_HALT(cpu_halt), .READY_IRQ(ready_irq), .NO_READ_WHILE_WRITE_SECTION_START(16'h3800),
    .LOCK_BITS(lock_bits), .FUSE_LOW(fuse_low), .FUSE_HIGH(fuse_high),
    .FUSE_EXT(fuse_ext), .SIG_BYTE(sig_byte), .FL_ERASE(fl_erase),
    .FL_WRITE(fl_write), .FL_PAGE_ADDR(fl_page_addr),
    .FL_BUF_WORD(fl_buf_word), .FL_BUF_ADDR(fl_buf_addr));
  //////////////////////////////////////////////////////////////////////////
  task automatic compare(input logic [15:0] e, input logic [15:0] a);
    comparisons++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [4:0] c, input logic st,
                     input logic [15:0] z);
    i_cpu.csr_write(1'($urandom), {3'h0, c});
    i_cpu.issue(st, z, data);
  endtask
  task automatic wait_idle();
    n = 0;
    while (io_rdata[0] !== 1'b0 && n < 200) begin
      settle(1);
      n++;
    end
    if (n == 200) begin
      errors++;
      final_report();
    end
  endtask
  // flash events and load answers against the queue
  always @(posedge clk) begin
    if (load_hit === 1'b1 || fl_erase === 1'b1 || fl_write === 1'b1) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
      compare(16'(want), {6'h00, fl_write, fl_erase,
        load_hit ? load_data : 8'h00});
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'hda74);
    {lock_bits, fuse_low, fuse_high, fuse_ext} = $urandom;
    {sig_byte, data} = 24'($urandom);
    settle(5);
    rst_n = 1'b1;
    settle(2);
    compare(16'(SPC_CSR_RESET), 16'(io_rdata));
    zs = '{SPC_FUSE_LOW_PTR, SPC_FUSE_HIGH_PTR, SPC_FUSE_EXT_PTR, 16'h0001};
    vs = '{fuse_low, fuse_high, fuse_ext, lock_bits};
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back({2'b00, vs[i]});
      cmd(SPC_CMD_LOCK, 1'b0, zs[i]);
      settle(6);
    end
    exp_q.push_back({2'b00, sig_byte});
    i_cpu.csr_write(1'b0, 8'(SPC_CMD_SIG));
    i_cpu.issue(1'b0, 16'h0000, data);
    settle(6);
    i_cpu.csr_write(1'b1, 8'(SPC_CMD_SIG));
    i_cpu.issue(1'b1, 16'h0000, data);
    compare(16'h0001, 16'(io_rdata[4:0]));
    settle(6);
    cmd(SPC_CMD_FILL, 1'b1, 16'h0105);
    compare(data, fl_buf_word);
    settle(6);
    compare(16'h0000, 16'(io_rdata[4:0]));
    i_cpu.csr_write(1'b0, {3'h0, SPC_CMD_WRITE});
    settle(2);
    compare(16'h0005, 16'(io_rdata[4:0]));
    settle(5);
    compare(16'h0000, 16'(io_rdata[4:0]));
    i_cpu.csr_write(1'b1, 8'h07);
    settle(2);
    compare(16'h0000, 16'(io_rdata[4:0]));
    from_boot = 1'b0;
    cmd(SPC_CMD_ERASE, 1'b1, 16'h0040);
    settle(6);
    from_boot = 1'b1;
    exp_q.push_back(10'h100);
    cmd(SPC_CMD_ERASE, 1'b1, 16'h01c6);
    settle(3);
    compare(16'h0180, fl_page_addr);
    compare(16'h0006, 16'({io_rdata[6], io_rdata[0], cpu_halt}));
    wait_idle();
    compare(16'h0001, 16'(n > PROG - 8));
    cmd(SPC_CMD_RWWRE, 1'b1, 16'h0000);
    settle(6);
    wait_idle();
    compare(16'h0000, 16'(io_rdata[6]));
    exp_q.push_back(10'h200);
    cmd(SPC_CMD_WRITE, 1'b1, 16'h3840);
    settle(3);
    compare(16'h0003, 16'({io_rdata[0], cpu_halt}));
    wait_idle();
    compare(16'h0000, 16'({io_rdata[6], cpu_halt}));
    compare(16'h3800, fl_page_addr);
    compare(16'h3800, fl_buf_addr);
    global_ie = 1'b1;
    i_cpu.csr_write(1'b1, 8'h80);
    settle(2);
    compare(16'h0001, 16'(ready_irq));
    ee_busy = 1'b1;
    settle(2);
    compare(16'h0000, 16'(ready_irq));
    ee_busy = 1'b0;
    i_cpu.csr_write(1'b0, 8'h81);
    settle(2);
    compare(16'h0000, 16'(ready_irq));
    settle(6);
    compare(16'h0001, 16'(ready_irq));
    compare(16'h0000, 16'(exp_q.size()));
    final_report();
  end
endmodule
